// ### src/pin_change_pkg.sv
// constants and carrier types for the pin change interrupt block
// assumes an 8-bit port and a plain address/strobe register port
package pin_change_pkg;
   localparam int port_width = 8;
   localparam int addr_width = 3;
   localparam logic [2:0] rise_en_offset = 3'h0;
   localparam logic [2:0] fall_en_offset = 3'h1;
   localparam logic [2:0] flag_offset = 3'h2;
   localparam logic [2:0] ctrl_offset = 3'h3;
   localparam logic [2:0] irq_mask_offset = 3'h4;
   localparam int ctrl_master_bit = 3;
   localparam int ctrl_summary_bit = 0;
   localparam logic [7:0] enable_reset = 8'h00;
   localparam logic [7:0] flag_reset = 8'h00;

   typedef struct packed {
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] prev;
      logic [7:0] rising_edge_enable_reg;
      logic [7:0] falling_edge_enable_reg;
      logic [7:0] pin_change_flag_reg;
      logic change_int_master_enable;
      logic irq_mask;
      logic [7:0] rdata;
   } state_t;
endpackage

// ### src/pin_change_interrupt.sv
// edge-detecting change interrupt for one 8-bit port
// assumes pins synchronous-capable inputs, single clock, one-cycle strobes
`timescale 1ns/1ps
module pin_change_interrupt (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] port_pins,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   output logic change_irq,
   output logic wake_request
);
   pin_change_pkg::state_t state_reg;
   pin_change_pkg::state_t state_next;
   logic [7:0] rise_pulse;
   logic [7:0] fall_pulse;
   logic [7:0] edge_hit;
   logic summary_flag;

   // per pin edge logic, every pin independent of the others
   genvar i;
   generate
      for (i = 0; i < pin_change_pkg::port_width; i++)
      begin : g_pin
         assign rise_pulse[i] = state_reg.sync2[i] & ~state_reg.prev[i];
         assign fall_pulse[i] = ~state_reg.sync2[i] & state_reg.prev[i];
         assign edge_hit[i] =
            (rise_pulse[i] & state_reg.rising_edge_enable_reg[i]) |
            (fall_pulse[i] & state_reg.falling_edge_enable_reg[i]);
      end
   endgenerate

   assign summary_flag = |state_reg.pin_change_flag_reg;

   always_comb
   begin
      state_next = state_reg;
      // prev sees only sync2; sync1 feeds nothing but sync2
      state_next.sync1 = port_pins;
      state_next.sync2 = state_reg.sync1;
      state_next.prev = state_reg.sync2;
      state_next.rdata = 8'h00;
      if (wr_en)
      begin
         case (addr)
            pin_change_pkg::rise_en_offset:
               state_next.rising_edge_enable_reg = wdata;
            pin_change_pkg::fall_en_offset:
               state_next.falling_edge_enable_reg = wdata;
            pin_change_pkg::flag_offset:
               state_next.pin_change_flag_reg =
                  state_reg.pin_change_flag_reg & wdata;
            pin_change_pkg::ctrl_offset:
               state_next.change_int_master_enable =
                  wdata[pin_change_pkg::ctrl_master_bit];
            pin_change_pkg::irq_mask_offset:
               state_next.irq_mask = wdata[0];
            default:
               state_next.irq_mask = state_reg.irq_mask;
         endcase
      end
      // set wins over a concurrent clear; flags set even when masked
      state_next.pin_change_flag_reg =
         state_next.pin_change_flag_reg | edge_hit;
      if (rd_en)
      begin
         case (addr)
            pin_change_pkg::rise_en_offset:
               state_next.rdata = state_reg.rising_edge_enable_reg;
            pin_change_pkg::fall_en_offset:
               state_next.rdata = state_reg.falling_edge_enable_reg;
            pin_change_pkg::flag_offset:
               state_next.rdata = state_reg.pin_change_flag_reg;
            pin_change_pkg::ctrl_offset:
            begin
               state_next.rdata[pin_change_pkg::ctrl_master_bit] =
                  state_reg.change_int_master_enable;
               state_next.rdata[pin_change_pkg::ctrl_summary_bit] =
                  summary_flag;
            end
            pin_change_pkg::irq_mask_offset:
               state_next.rdata[0] = state_reg.irq_mask;
            default:
               state_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= '0;
         state_reg.rising_edge_enable_reg <=
            pin_change_pkg::enable_reset;
         state_reg.falling_edge_enable_reg <= pin_change_pkg::enable_reset;
         state_reg.pin_change_flag_reg <= pin_change_pkg::flag_reset;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign rdata = state_reg.rdata;
   // level request; the unmasked bit gates the core-facing output
   assign change_irq = summary_flag & state_reg.change_int_master_enable &
      state_reg.irq_mask;
   // wake only needs the master enable; flags are already latched
   assign wake_request = summary_flag &
      state_reg.change_int_master_enable;

   rise_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
      (rise_pulse[0] && state_reg.rising_edge_enable_reg[0])
      |=> state_reg.pin_change_flag_reg[0])
      else $error("rising edge did not set flag");
   fall_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
      (fall_pulse[7] && state_reg.falling_edge_enable_reg[7])
      |=> state_reg.pin_change_flag_reg[7])
      else $error("falling edge did not set flag");
   no_arm_a: assert property (@(posedge clock) disable iff (!rst_n)
      (!state_reg.pin_change_flag_reg[1] &&
       !state_reg.rising_edge_enable_reg[1] &&
       !state_reg.falling_edge_enable_reg[1])
      |=> !state_reg.pin_change_flag_reg[1])
      else $error("flag set on disarmed pin");
   set_wins_a: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_en && addr == pin_change_pkg::flag_offset && edge_hit[2])
      |=> state_reg.pin_change_flag_reg[2])
      else $error("edge lost during flag write");
   clear_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_en && addr == pin_change_pkg::flag_offset && !wdata[3] &&
       !edge_hit[3]) |=> !state_reg.pin_change_flag_reg[3])
      else $error("flag not cleared by zero");
   irq_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
      change_irq |-> (state_reg.change_int_master_enable && summary_flag))
      else $error("irq without master enable");
   irq_raise_a: assert property (@(posedge clock) disable iff (!rst_n)
      (edge_hit[4] && state_reg.change_int_master_enable &&
       state_reg.irq_mask && !wr_en) |=> change_irq)
      else $error("irq not raised");
   pulse_one_a: assert property (@(posedge clock) disable iff (!rst_n)
      rise_pulse[5] |=> !rise_pulse[5])
      else $error("edge pulse longer than a cycle");
   sync_edge_a: assert property (@(posedge clock) disable iff (!rst_n)
      ($rose(port_pins[6]) && !state_reg.sync1[6]) ##2 1 |-> rise_pulse[6])
      else $error("edge pulse not on time");
   summary_rd_a: assert property (@(posedge clock) disable iff (!rst_n)
      (rd_en && addr == pin_change_pkg::ctrl_offset)
      |=> rdata[0] == $past(summary_flag))
      else $error("summary flag read wrong");

   // the pin checks above watch one pin each; a slip in the loop index
   // would pass them, so every pin gets them below, bar sync_edge_a and irq_raise_a
   genvar k;
   generate
      for (k = 0; k < pin_change_pkg::port_width; k++)
      begin : g_pin_chk
         rise_arm_a: assert property (@(posedge clock) disable iff (!rst_n)
            (rise_pulse[k] && state_reg.rising_edge_enable_reg[k])
            |=> state_reg.pin_change_flag_reg[k])
            else $error("armed rising edge lost");
         fall_arm_a: assert property (@(posedge clock) disable iff (!rst_n)
            (fall_pulse[k] && state_reg.falling_edge_enable_reg[k])
            |=> state_reg.pin_change_flag_reg[k])
            else $error("armed falling edge lost");
         quiet_pin_a: assert property (@(posedge clock) disable iff (!rst_n)
            (!state_reg.pin_change_flag_reg[k] &&
             !(rise_pulse[k] && state_reg.rising_edge_enable_reg[k]) &&
             !(fall_pulse[k] && state_reg.falling_edge_enable_reg[k]))
            |=> !state_reg.pin_change_flag_reg[k])
            else $error("flag set without armed edge");
         flag_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
            (state_reg.pin_change_flag_reg[k] &&
             !(wr_en && addr == pin_change_pkg::flag_offset))
            |=> state_reg.pin_change_flag_reg[k])
            else $error("flag dropped without a write");
         pin_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
            (wr_en && addr == pin_change_pkg::flag_offset && !wdata[k] &&
             !edge_hit[k]) |=> !state_reg.pin_change_flag_reg[k])
            else $error("zero write left flag set");
         pin_race_a: assert property (@(posedge clock) disable iff (!rst_n)
            (wr_en && addr == pin_change_pkg::flag_offset && edge_hit[k])
            |=> state_reg.pin_change_flag_reg[k])
            else $error("edge lost in clear write");
         rise_short_a: assert property (@(posedge clock) disable iff (!rst_n)
            rise_pulse[k] |=> !rise_pulse[k])
            else $error("rising pulse too long");
         fall_short_a: assert property (@(posedge clock) disable iff (!rst_n)
            fall_pulse[k] |=> !fall_pulse[k])
            else $error("falling pulse too long");
         one_dir_a: assert property (@(posedge clock) disable iff (!rst_n)
            !(rise_pulse[k] && fall_pulse[k]))
            else $error("both edge pulses at once");
         pin_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
            (state_reg.pin_change_flag_reg[k] &&
             state_reg.change_int_master_enable && state_reg.irq_mask)
            |-> change_irq)
            else $error("pin flag gave no request");
         pin_wake_a: assert property (@(posedge clock) disable iff (!rst_n)
            (state_reg.pin_change_flag_reg[k] &&
             state_reg.change_int_master_enable) |-> wake_request)
            else $error("pin flag gave no wake");
      end
   endgenerate

   // request outputs against the gating bits, both ways
   master_off_a: assert property (@(posedge clock) disable iff (!rst_n)
      !state_reg.change_int_master_enable |-> (!change_irq && !wake_request))
      else $error("request with master off");
   mask_off_a: assert property (@(posedge clock) disable iff (!rst_n)
      !state_reg.irq_mask |-> !change_irq)
      else $error("request with mask off");
   irq_level_a: assert property (@(posedge clock) disable iff (!rst_n)
      (summary_flag && state_reg.change_int_master_enable &&
       state_reg.irq_mask) |-> change_irq)
      else $error("request missing");
   wake_level_a: assert property (@(posedge clock) disable iff (!rst_n)
      (summary_flag && state_reg.change_int_master_enable) |-> wake_request)
      else $error("wake missing");
   wake_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
      wake_request |-> (summary_flag && state_reg.change_int_master_enable))
      else $error("wake without cause");

   // register port: writes land next cycle, reads stand one cycle only
   rise_wr_a: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_en && addr == pin_change_pkg::rise_en_offset)
      |=> state_reg.rising_edge_enable_reg == $past(wdata))
      else $error("rising enable write lost");
   fall_wr_a: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_en && addr == pin_change_pkg::fall_en_offset)
      |=> state_reg.falling_edge_enable_reg == $past(wdata))
      else $error("falling enable write lost");
   master_wr_a: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_en && addr == pin_change_pkg::ctrl_offset)
      |=> state_reg.change_int_master_enable == $past(wdata[3]))
      else $error("master enable write lost");
   mask_wr_a: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_en && addr == pin_change_pkg::irq_mask_offset)
      |=> state_reg.irq_mask == $past(wdata[0]))
      else $error("mask write lost");
   unmapped_wr_a: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_en && addr > pin_change_pkg::irq_mask_offset)
      |=> (state_reg.rising_edge_enable_reg ==
           $past(state_reg.rising_edge_enable_reg)))
      else $error("unmapped write changed state");
   rise_rd_a: assert property (@(posedge clock) disable iff (!rst_n)
      (rd_en && addr == pin_change_pkg::rise_en_offset)
      |=> rdata == $past(state_reg.rising_edge_enable_reg))
      else $error("rising enable read wrong");
   fall_rd_a: assert property (@(posedge clock) disable iff (!rst_n)
      (rd_en && addr == pin_change_pkg::fall_en_offset)
      |=> rdata == $past(state_reg.falling_edge_enable_reg))
      else $error("falling enable read wrong");
   flag_rd_a: assert property (@(posedge clock) disable iff (!rst_n)
      (rd_en && addr == pin_change_pkg::flag_offset)
      |=> rdata == $past(state_reg.pin_change_flag_reg))
      else $error("flag read wrong");
   master_rd_a: assert property (@(posedge clock) disable iff (!rst_n)
      (rd_en && addr == pin_change_pkg::ctrl_offset)
      |=> rdata[3] == $past(state_reg.change_int_master_enable))
      else $error("master enable read wrong");
   unmapped_rd_a: assert property (@(posedge clock) disable iff (!rst_n)
      (rd_en && addr > pin_change_pkg::irq_mask_offset) |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   rdata_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
      !rd_en |=> rdata == 8'h00)
      else $error("read data outside its cycle");

   // no disable here: the first edge after release must see cleared state
   reset_clear_a: assert property (@(posedge clock)
      (rst_n && !$past(rst_n)) |-> (!state_reg.change_int_master_enable &&
       state_reg.rising_edge_enable_reg == 8'h00 &&
       state_reg.falling_edge_enable_reg == 8'h00 &&
       state_reg.pin_change_flag_reg == 8'h00))
      else $error("state not cleared by reset");
endmodule

// ### test/pin_source.sv
// external signals on the port pins, one level per bench request
// assumes requests are made just after a rising clock edge
`timescale 1ns/1ps
module pin_source (
   input wire logic clock,
   input wire logic [7:0] level_req,
   output logic [7:0] port_pins
);
   // levels move on the clock so no pulse is shorter than a cycle
   always_ff @(posedge clock)
   begin
      port_pins <= level_req;
   end
endmodule

// ### test/test_pin_change_interrupt.sv
// self-checking bench for the pin change interrupt block
// assumes pin_source drives the pins and the bench is the core
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
   $display("wrong value %s exp %h got %h", n, e, g); n_errors++; end end
module test_pin_change_interrupt;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] level_req = 8'h00;
   logic [7:0] rdata, port_pins, got, exp_flags, rise, fall, old;
   logic change_irq, wake_request, master;
   logic [31:0] lfsr = 32'h88E3C995;
   int n_errors = 0;
   int tests_run = 0;
   pin_change_interrupt pin_change_interrupt_i (.clock(clock),
      .rst_n(rst_n), .port_pins(port_pins), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .change_irq(change_irq), .wake_request(wake_request));
   pin_source pin_source_i (.clock(clock), .level_req(level_req),
      .port_pins(port_pins));
   initial
   begin
      forever #4 clock = ~clock;
   end
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] edges(input logic [7:0] o, n, r, f);
      return (r & ~o & n) | (f & o & ~n);
   endfunction
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 got = rdata;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      wr(3'h5, 8'hFF);
      for (int a = 0; a < 6; a++)
      begin
         rd(a[2:0]);
         `CHK("reset value", 8'h00, got)
      end
      wr(pin_change_pkg::irq_mask_offset, 8'h01);
      for (int i = 0; i < 16; i++)
      begin
         repeat (17) lfsr = step(lfsr);
         rise = lfsr[7:0];
         fall = lfsr[15:8];
         master = lfsr[16];
         wr(pin_change_pkg::rise_en_offset, rise);
         wr(pin_change_pkg::fall_en_offset, fall);
         wr(pin_change_pkg::ctrl_offset,
            8'(master) << pin_change_pkg::ctrl_master_bit);
         rd(pin_change_pkg::flag_offset);
         wr(pin_change_pkg::flag_offset, ~got);
         old = level_req;
         level_req <= lfsr[31:24];
         exp_flags = edges(old, lfsr[31:24], rise, fall);
         repeat (5) @(posedge clock);
         rd(pin_change_pkg::flag_offset);
         `CHK("flags", exp_flags, got)
         `CHK("irq", master & (|exp_flags), change_irq)
         `CHK("wake", master & (|exp_flags), wake_request)
         rd(pin_change_pkg::ctrl_offset);
         `CHK("ctrl", {4'h0, master, 2'h0, |exp_flags}, got)
         $display("test %0d done", i);
      end
      // edge lands in the same cycle as a clear-all write
      wr(pin_change_pkg::rise_en_offset, 8'hFF);
      wr(pin_change_pkg::fall_en_offset, 8'hFF);
      wr(pin_change_pkg::ctrl_offset, 8'h08);
      level_req <= level_req ^ 8'h01;
      repeat (2) @(posedge clock);
      wr(pin_change_pkg::flag_offset, 8'h00);
      rd(pin_change_pkg::flag_offset);
      `CHK("race flag", 8'h01, got)
      `CHK("irq set", 1'b1, change_irq)
      wr(pin_change_pkg::irq_mask_offset, 8'h00);
      #1 `CHK("irq masked", 1'b0, change_irq)
      wr(pin_change_pkg::flag_offset, 8'h00);
      #1 `CHK("wake cleared", 1'b0, wake_request)
      $display("test race done");
      report_and_stop();
   end
endmodule
